// ===== lane_ctl_defs.svh
// Register offsets, field positions, reset values and timing figures of the lane control block
`ifndef LANE_CTL_DEFS_SVH
`define LANE_CTL_DEFS_SVH
`define LOOP_OFS       12'h000
`define DBG_OFS        12'h004
`define COEF_OFS       12'h008
`define EQ_OFS         12'h02C
`define PAT_OFS        12'h030
`define GEN_OFS        12'h034
`define STAT_OFS       12'h050
`define LOOP_RST       32'h00000002
`define DBG_RST        32'h30000000
`define COEF_RST       32'h00000002
`define EQ_RST         32'h00000803
`define PAT_RST        32'h00000000
`define GEN_RST        32'h00000000
`define LOOP_WMASK     32'hC0F000C3
`define DBG_WMASK      32'h3C0400FF
`define COEF_WMASK     32'h00000FFF
`define EQ_WMASK       32'hFFFFFFFF
`define PAT_WMASK      32'hFFFD3800
`define GEN_WMASK      32'h00000043
`define RXCLK_LB_BIT   31
`define NES_LB_BIT     30
`define TXOUT_CLK_BIT  23
`define FIFO_SRC_LSB   20
`define ENC_SRC_LSB    6
`define RXPATH_CLK_BIT 1
`define TXPATH_CLK_BIT 0
`define ATT_LSB        26
`define C2_MSB_BIT     18
`define CHK_CLK_BIT    7
`define CHK_TAP_LSB    5
`define CHK_CLR_BIT    4
`define CHK_EN_BIT     3
`define SIGDET_LSB     1
`define LANECLK_BIT    0
`define CM_LSB         8
`define C2_LOW_LSB     5
`define C1_LSB         0
`define EYE_LSB        24
`define PHD_LSB        22
`define BW_LSB         20
`define PD_BIAS_BIT    19
`define LDEN_HI_LSB    16
`define LDEN_LO_LSB    12
`define ATT_BYP_BIT    11
`define EQ_LATCH_BIT   10
`define LOAD_HI_LSB    8
`define LOAD_LO_LSB    3
`define EQ_OVR_BIT     2
`define EQ_EN_BIT      1
`define EQ_WAIT_BIT    0
`define PRE0_LSB       24
`define BIST_RXCLK_BIT 23
`define BIST_TXCLK_BIT 22
`define PRBS_LSB       19
`define PAT_MODE_BIT   18
`define BYTE_MODE_BIT  16
`define GEN_WORD_BIT   6
`define PRE0_HI_LSB    0
`define EQ_RECOVERY_NS 5000
`define CLK_PERIOD_NS  4
`endif

// ===== lane_ctl_pkg.sv
// Types shared by the lane control block
package lane_ctl_pkg;
	typedef enum logic [1:0] {CDR_IDLE, CDR_ATT, CDR_DFE, CDR_RUN} cdrState_t;
	typedef enum logic [1:0] {CHK_OFF, CHK_WAIT, CHK_RUN} chkState_t;
	typedef struct packed {
		logic [3:0] attenuation;
		logic [3:0] commonMode;
		logic [4:0] preTap;
		logic [3:0] postTap;
	} drvOverride_t;
	typedef struct packed {
		logic       overrideEnable;
		logic       blockEnable;
		logic [6:0] loadValue;
		logic [6:0] loadEnable;
		logic [1:0] bandwidth;
		logic [1:0] phaseDetBlock;
		logic       eyeCoarse;
		logic [6:0] eyeFine;
	} eqOverride_t;
	typedef struct packed {
		logic [9:0] preamble0;
		logic       kIndicator;
		logic       patternPrbs;
		logic [2:0] prbsSelect;
		logic [4:0] busWidth;
		logic       rxClockEnable;
		logic       txClockEnable;
	} bistPattern_t;
	typedef struct packed {
		logic recoveredClockLoopbackEnable;
		logic nearEndSerialLoopbackEnable;
		logic txOutputClockSelect;
		logic rxPathClockSelect;
		logic txPathClockSelect;
		logic txLaneClockOutputSelect;
		logic checkerResetClockSelect;
	} loopClk_t;
endpackage

// ===== lane_loopback_bist_ctrl.sv
// Lane loopback, BIST and equalizer/CDR override control with APB register access
`timescale 1ns/1ns
`include "lane_ctl_defs.svh"
module lane_loopback_bist_ctrl #(
	parameter int DW = 20,
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	// Transmit data path
	input  wire logic [DW-1:0]              socTxData,
	input  wire logic [DW-1:0]              decodedRxData,
	input  wire logic [DW-1:0]              bistGenData,
	input  wire logic [DW-1:0]              encodedData,
	input  wire logic [DW-1:0]              pmaRxData,
	input  wire logic [DW-1:0]              elasticRxData,
	input  wire logic                       pcieLoopback,
	output logic [DW-1:0]                   encoderInput,
	output logic [DW-1:0]                   fifoInput,
	// Checker taps and status
	input  wire logic [DW-1:0]              tapPolarity,
	input  wire logic [DW-1:0]              tapAligner,
	input  wire logic [DW-1:0]              tapLoopMux,
	input  wire logic [DW-1:0]              tapReg1,
	input  wire logic                       checkerErrorPulse,
	output logic [DW-1:0]                   checkerData,
	output logic                            checkerRun,
	output logic [CW-1:0]                   checkerErrorCount,
	// Loopback and clock selects
	input  wire logic                       farEndParallelLoopback,
	output lane_ctl_pkg::loopClk_t          loopClk,
	// Analogue front end
	input  wire logic                       signalDetectRaw,
	input  wire logic                       msmOutOverrideEnable,
	input  wire logic                       attCalDone,
	input  wire logic                       dfeCalDone,
	output logic                            signalDetect,
	output lane_ctl_pkg::drvOverride_t      drvOverride,
	output lane_ctl_pkg::eqOverride_t       eqOverride,
	output logic                            equalizerBiasPowerdown,
	output logic                            equalizerReady,
	output logic                            equalizerCapture,
	output logic                            attCalEnable,
	output logic                            cdrInputSelect,
	output logic                            rxDataEnable,
	// BIST pattern
	output lane_ctl_pkg::bistPattern_t      bistPattern
);
	localparam int RECOVERY_CYCLES = (`EQ_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	logic [31:0] loopQ, dbgQ, coefQ, eqQ, patQ, genQ;
	logic [10:0] recoveryQ;
	logic        latchPrevQ;
	logic        biasPdD;
	lane_ctl_pkg::cdrState_t cdrStateQ;
	lane_ctl_pkg::chkState_t chkStateQ;

	////////////////////////////////////////////////////////////////////////
	// Register decode

	// Index 0 to 6 of a mapped register, 7 when unmapped
	function automatic logic [2:0] regIndex(input logic [11:0] a);
		case (a)
			`LOOP_OFS: regIndex = 3'h0;
			`DBG_OFS:  regIndex = 3'h1;
			`COEF_OFS: regIndex = 3'h2;
			`EQ_OFS:   regIndex = 3'h3;
			`PAT_OFS:  regIndex = 3'h4;
			`GEN_OFS:  regIndex = 3'h5;
			`STAT_OFS: regIndex = 3'h6;
			default:   regIndex = 3'h7;
		endcase
	endfunction

	logic [31:0] statusWord;
	logic [31:0] readWord;
	logic        wrEn;
	always_comb begin
		statusWord = 32'h00000000;
		statusWord[CW-1:0] = checkerErrorCount;
		statusWord[16] = checkerRun;
		statusWord[17] = rxDataEnable;
		statusWord[18] = signalDetect;
		statusWord[19] = equalizerReady;
		statusWord[21:20] = cdrStateQ;
		case (regIndex(paddr))
			3'h0:    readWord = loopQ;
			3'h1:    readWord = dbgQ;
			3'h2:    readWord = coefQ;
			3'h3:    readWord = eqQ;
			3'h4:    readWord = patQ;
			3'h5:    readWord = genQ;
			3'h6:    readWord = statusWord;
			default: readWord = 32'h00000000;
		endcase
	end
	assign wrEn = psel && penable && pready && pwrite;

	// One wait-free access phase: answer is ready in the cycle after setup
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? readWord : 32'h00000000;
			pslverr <= psel && !penable && (regIndex(paddr) == 3'h7 || (pwrite && regIndex(paddr) == 3'h6));
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			loopQ <= `LOOP_RST;
			dbgQ  <= `DBG_RST;
			coefQ <= `COEF_RST;
			eqQ   <= `EQ_RST;
			patQ  <= `PAT_RST;
			genQ  <= `GEN_RST;
		end else if (wrEn) begin
			case (regIndex(paddr))
				3'h0:    loopQ <= pwdata & `LOOP_WMASK;
				3'h1:    dbgQ  <= pwdata & `DBG_WMASK;
				3'h2:    coefQ <= pwdata & `COEF_WMASK;
				3'h3:    eqQ   <= pwdata & `EQ_WMASK;
				3'h4:    patQ  <= pwdata & `PAT_WMASK;
				3'h5:    genQ  <= pwdata & `GEN_WMASK;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data path muxes

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			encoderInput <= '0;
		end else begin
			case (loopQ[`ENC_SRC_LSB +: 2])
				2'h1:    encoderInput <= decodedRxData;
				2'h2:    encoderInput <= bistGenData;
				// reserved code falls back to SoC data
				default: encoderInput <= socTxData;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fifoInput <= '0;
		end else begin
			case (loopQ[`FIFO_SRC_LSB +: 3])
				3'h1:    fifoInput <= encodedData;
				3'h3:    fifoInput <= bistGenData;
				3'h5:    fifoInput <= pmaRxData;
				3'h7:    fifoInput <= elasticRxData;
				default: fifoInput <= pcieLoopback ? elasticRxData : encodedData;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			checkerData <= '0;
		end else begin
			case (dbgQ[`CHK_TAP_LSB +: 2])
				2'h0:    checkerData <= tapPolarity;
				2'h1:    checkerData <= tapAligner;
				2'h2:    checkerData <= tapLoopMux;
				default: checkerData <= tapReg1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock selects and static overrides

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			loopClk      <= '0;
			drvOverride  <= '0;
			eqOverride   <= '0;
			bistPattern  <= '0;
			signalDetect <= 1'b0;
		end else begin
			loopClk.recoveredClockLoopbackEnable <= loopQ[`RXCLK_LB_BIT];
			loopClk.nearEndSerialLoopbackEnable  <= loopQ[`NES_LB_BIT];
			loopClk.txOutputClockSelect          <= loopQ[`TXOUT_CLK_BIT];
			loopClk.rxPathClockSelect            <= loopQ[`RXPATH_CLK_BIT] && farEndParallelLoopback;
			loopClk.txPathClockSelect            <= loopQ[`TXPATH_CLK_BIT] && farEndParallelLoopback;
			loopClk.txLaneClockOutputSelect      <= dbgQ[`LANECLK_BIT] && farEndParallelLoopback;
			loopClk.checkerResetClockSelect      <= dbgQ[`CHK_CLK_BIT];
			signalDetect <= dbgQ[`SIGDET_LSB + 1] ? dbgQ[`SIGDET_LSB] : signalDetectRaw;
			// driver overrides, C2 joined from two fields
			drvOverride.attenuation <= dbgQ[`ATT_LSB +: 4];
			drvOverride.commonMode  <= coefQ[`CM_LSB +: 4];
			drvOverride.preTap      <= coefQ[`C1_LSB +: 5];
			drvOverride.postTap     <= {dbgQ[`C2_MSB_BIT], coefQ[`C2_LOW_LSB +: 3]};
			// eye offset coarse half-UI and fine parts
			eqOverride.eyeCoarse      <= eqQ[`EYE_LSB + 7];
			eqOverride.eyeFine        <= eqQ[`EYE_LSB +: 7];
			eqOverride.phaseDetBlock  <= eqQ[`PHD_LSB +: 2];
			eqOverride.bandwidth      <= eqQ[`BW_LSB +: 2];
			eqOverride.overrideEnable <= eqQ[`EQ_OVR_BIT];
			eqOverride.blockEnable    <= eqQ[`EQ_EN_BIT];
			eqOverride.loadValue      <= {eqQ[`LOAD_HI_LSB +: 2], eqQ[`LOAD_LO_LSB +: 5]};
			eqOverride.loadEnable     <= {eqQ[`LDEN_HI_LSB +: 3], eqQ[`LDEN_LO_LSB +: 4]};
			bistPattern.preamble0     <= {genQ[`PRE0_HI_LSB +: 2], patQ[`PRE0_LSB +: 8]};
			bistPattern.kIndicator    <= patQ[`BYTE_MODE_BIT] && genQ[`PRE0_HI_LSB];
			bistPattern.rxClockEnable <= patQ[`BIST_RXCLK_BIT];
			bistPattern.txClockEnable <= patQ[`BIST_TXCLK_BIT];
			bistPattern.patternPrbs   <= patQ[`PAT_MODE_BIT];
			bistPattern.prbsSelect    <= patQ[`PRBS_LSB +: 3];
			// word width from byte mode and double word
			case ({patQ[`BYTE_MODE_BIT], genQ[`GEN_WORD_BIT]})
				2'b00:   bistPattern.busWidth <= 5'h0A;
				2'b01:   bistPattern.busWidth <= 5'h14;
				2'b10:   bistPattern.busWidth <= 5'h08;
				default: bistPattern.busWidth <= 5'h10;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Equalizer bias powerdown and latch

	// override only under state-machine override enable
	assign biasPdD = eqQ[`PD_BIAS_BIT] && msmOutOverrideEnable;

	// Recovery holds the equalizer not ready so, with EQ_WAIT_BIT set, the CDR cannot leave CDR_DFE while bias settles
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			equalizerBiasPowerdown <= 1'b0;
			recoveryQ              <= '0;
			equalizerReady         <= 1'b0;
		end else begin
			equalizerBiasPowerdown <= biasPdD;
			if (biasPdD)
				recoveryQ <= 11'(RECOVERY_CYCLES);
			else if (recoveryQ != 11'h000)
				recoveryQ <= recoveryQ - 11'h001;
			equalizerReady <= !biasPdD && recoveryQ == 11'h000 && eqQ[`EQ_EN_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			latchPrevQ       <= 1'b0;
			equalizerCapture <= 1'b0;
		end else begin
			latchPrevQ <= eqQ[`EQ_LATCH_BIT];
			equalizerCapture <= latchPrevQ && !eqQ[`EQ_LATCH_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CDR sequencing

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cdrStateQ <= lane_ctl_pkg::CDR_IDLE;
		end else if (!signalDetect) begin
			cdrStateQ <= lane_ctl_pkg::CDR_IDLE;
		end else begin
			case (cdrStateQ)
				lane_ctl_pkg::CDR_IDLE: cdrStateQ <= lane_ctl_pkg::CDR_ATT;
				lane_ctl_pkg::CDR_ATT:
					if (eqQ[`ATT_BYP_BIT] || attCalDone)
						cdrStateQ <= lane_ctl_pkg::CDR_DFE;
				lane_ctl_pkg::CDR_DFE:
					if (!eqQ[`EQ_WAIT_BIT] || (dfeCalDone && equalizerReady))
						cdrStateQ <= lane_ctl_pkg::CDR_RUN;
				lane_ctl_pkg::CDR_RUN: cdrStateQ <= lane_ctl_pkg::CDR_RUN;
				default: cdrStateQ <= lane_ctl_pkg::CDR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			attCalEnable   <= 1'b0;
			cdrInputSelect <= 1'b0;
			rxDataEnable   <= 1'b0;
		end else begin
			attCalEnable   <= cdrStateQ != lane_ctl_pkg::CDR_IDLE;
			cdrInputSelect <= cdrStateQ == lane_ctl_pkg::CDR_DFE || cdrStateQ == lane_ctl_pkg::CDR_RUN;
			rxDataEnable   <= cdrStateQ == lane_ctl_pkg::CDR_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checker control and error count

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chkStateQ  <= lane_ctl_pkg::CHK_OFF;
			checkerRun <= 1'b0;
		end else begin
			case (chkStateQ)
				lane_ctl_pkg::CHK_OFF:
					if (dbgQ[`CHK_EN_BIT])
						chkStateQ <= lane_ctl_pkg::CHK_WAIT;
				lane_ctl_pkg::CHK_WAIT:
					if (!dbgQ[`CHK_EN_BIT])
						chkStateQ <= lane_ctl_pkg::CHK_OFF;
					else if (signalDetect && patQ[`BIST_RXCLK_BIT])
						chkStateQ <= lane_ctl_pkg::CHK_RUN;
				lane_ctl_pkg::CHK_RUN:
					if (!dbgQ[`CHK_EN_BIT])
						chkStateQ <= lane_ctl_pkg::CHK_OFF;
					else if (!signalDetect)
						chkStateQ <= lane_ctl_pkg::CHK_WAIT;
				default: chkStateQ <= lane_ctl_pkg::CHK_OFF;
			endcase
			checkerRun <= chkStateQ == lane_ctl_pkg::CHK_RUN && dbgQ[`CHK_EN_BIT] && signalDetect;
		end
	end

	// Counter saturates so a long soak never wraps to a clean-looking value
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			checkerErrorCount <= '0;
		else if (dbgQ[`CHK_CLR_BIT])
			checkerErrorCount <= '0;
		else if (checkerRun && checkerErrorPulse && checkerErrorCount != {CW{1'b1}})
			checkerErrorCount <= checkerErrorCount + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	encSource_a: assert property ($past(loopQ[`ENC_SRC_LSB +: 2]) == 2'h2 |-> encoderInput == $past(bistGenData))
		else $error("encoder source 2 did not pass BIST data");
	fifoSource_a: assert property ($past(loopQ[`FIFO_SRC_LSB +: 3]) == 3'h0 && $past(pcieLoopback)
		|-> fifoInput == $past(elasticRxData))
		else $error("even FIFO source ignored PCIe loopback");
	fepGate_a: assert property (!$past(farEndParallelLoopback)
		|-> !loopClk.rxPathClockSelect && !loopClk.txPathClockSelect)
		else $error("path clock select active outside far-end loopback");
	checkerClear_a: assert property ($past(dbgQ[`CHK_CLR_BIT]) |-> checkerErrorCount == '0)
		else $error("error count not zero after clear");
	checkerGate_a: assert property (checkerRun |-> $past(dbgQ[`CHK_EN_BIT]) && $past(chkStateQ) == lane_ctl_pkg::CHK_RUN)
		else $error("checker ran without enable");
	sigdetForce_a: assert property ($past(dbgQ[`SIGDET_LSB + 1]) |-> signalDetect == $past(dbgQ[`SIGDET_LSB]))
		else $error("forced signal detect not applied");
	biasGate_a: assert property (!$past(msmOutOverrideEnable) |-> !equalizerBiasPowerdown)
		else $error("bias powerdown without override enable");
	biasRecovery_a: assert property ($fell(equalizerBiasPowerdown) |-> !equalizerReady [*8])
		else $error("equalizer ready too soon after powerdown");
	latchCapture_a: assert property (equalizerCapture |-> $past(eqQ[`EQ_LATCH_BIT], 2) && !$past(eqQ[`EQ_LATCH_BIT]))
		else $error("capture without falling latch");
	attWait_a: assert property (cdrStateQ == lane_ctl_pkg::CDR_ATT && !eqQ[`ATT_BYP_BIT] && !attCalDone && signalDetect
		|=> cdrStateQ == lane_ctl_pkg::CDR_ATT)
		else $error("CDR left attenuator wait early");

	rxEnabled_c: cover property (cdrStateQ == lane_ctl_pkg::CDR_DFE ##[1:20] rxDataEnable);
	checkerErr_c: cover property (checkerRun && checkerErrorPulse ##1 checkerErrorCount != '0);
	capture_c: cover property (equalizerCapture);
endmodule

// ===== lane_fe_model.sv
// Far-side model: lane data, checker taps, signal and calibration replies
`timescale 1ns/1ns
module lane_fe_model #(
	parameter int DW = 20
) (
	// Clock and calibration request
	input  wire logic     core_clk,
	input  wire logic     attCalEnable,
	// Data, taps and analogue status
	output logic [DW-1:0] dat [10],
	output logic          sigRaw,
	output logic          errPulse,
	output logic          calDone
);
	logic [3:0] wait_q;
	initial begin
		foreach (dat[i]) dat[i] = '0;
		{sigRaw, errPulse, calDone, wait_q} = '0;
	end
	// New values every cycle, so a stale or wrong mux pick shows at once
	always @(posedge core_clk) begin
		foreach (dat[i]) dat[i] <= DW'($urandom);
		sigRaw <= 1'($urandom);
		errPulse <= 1'($urandom);
		wait_q <= attCalEnable ? wait_q + 4'(wait_q != 4'hF) : 4'h0;
		calDone <= wait_q == 4'hF;
	end
endmodule

// ===== lane_loopback_bist_ctrl_bench.sv
// Self-checking bench for the lane loopback, BIST and equalizer control block
`timescale 1ns/1ns
module lane_loopback_bist_ctrl_bench;
	localparam int DW = 20;
	logic                       core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0]                paddr;
	logic [31:0]                pwdata, prdata;
	logic                       pcie, fep, msm, sigRaw, errPulse, calDone, attCalEnable;
	logic                       checkerRun, signalDetect, equalizerBiasPowerdown;
	logic                       eqReady, eqCapture, cdrSel, rxEn;
	logic [DW-1:0]              dat [10];
	logic [DW-1:0]              encoderInput, fifoInput, checkerData;
	logic [15:0]                checkerErrorCount;
	lane_ctl_pkg::loopClk_t     loopClk;
	lane_ctl_pkg::drvOverride_t drvOverride;
	lane_ctl_pkg::eqOverride_t  eqOverride;
	lane_ctl_pkg::bistPattern_t bistPattern;
	logic [32:0]                expQ [$];
	logic [32:0]                note;
	int                         n_errors = 0;
	int                         n_compared = 0;
	int                         cyc = 0;
	////////////////////////////////////////
	lane_loopback_bist_ctrl #(.DW(DW), .CW(16)) dut (
		.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.socTxData(dat[0]), .decodedRxData(dat[1]), .bistGenData(dat[2]), .encodedData(dat[3]),
		.pmaRxData(dat[4]), .elasticRxData(dat[5]), .pcieLoopback(pcie), .encoderInput, .fifoInput,
		.tapPolarity(dat[6]), .tapAligner(dat[7]), .tapLoopMux(dat[8]), .tapReg1(dat[9]),
		.checkerErrorPulse(errPulse), .checkerData, .checkerRun, .checkerErrorCount,
		.farEndParallelLoopback(fep), .loopClk, .signalDetectRaw(sigRaw), .msmOutOverrideEnable(msm),
		.attCalDone(calDone), .dfeCalDone(calDone), .signalDetect, .drvOverride, .eqOverride,
		.equalizerBiasPowerdown, .equalizerReady(eqReady), .equalizerCapture(eqCapture), .attCalEnable,
		.cdrInputSelect(cdrSel), .rxDataEnable(rxEn), .bistPattern
	);
	lane_fe_model #(.DW(DW)) farEnd (.core_clk, .attCalEnable, .dat, .sigRaw, .errPulse, .calDone);
	////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic test_done();
		$display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held from setup until pready is sampled high
	// No local limit: only the bench timeout may end a wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Reads are judged against the oldest note as each access completes
	always @(posedge core_clk) begin
		cyc++;
		if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
			note = expQ.pop_front();
			chk(prdata, note[31:0]);
			chk(32'(pslverr), 32'(note[32]));
		end
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end
	////////////////////////////////////////
	initial begin
		logic [31:0]   v0, v4, v8;
		logic [DW-1:0] eE, eF, eT;
		logic          sd;
		int            odd [4] = '{3, 2, 4, 5};
		logic [4:0]    wd [4] = '{5'h0A, 5'h14, 5'h08, 5'h10};
		void'($urandom(32'hCACE));
		{reset_n, psel, penable, pwrite, paddr, pwdata, pcie, fep, msm} <= '0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(12'h000, 33'h000000002);
		rd(12'h004, 33'h030000000);
		rd(12'h008, 33'h000000002);
		rd(12'h02C, 33'h000000803);
		rd(12'h030, 33'h000000000);
		rd(12'h0FC, 33'h100000000);
		$display("reset values and unmapped read done");
		// Every encoder and FIFO mux code with both PCIe loopback levels; other fields random except TX output clock select, checker enable and clear, held at 0
		for (int i = 0; i < 16; i++) begin
			v0 = ($urandom & 32'hFF0FFF3F) | (32'(i[1:0]) << 6) | (32'(i[2:0]) << 20);
			v4 = $urandom & 32'hFFFFFFE7;
			v8 = $urandom;
			apb(1'b1, 12'h000, v0);
			apb(1'b1, 12'h004, v4);
			apb(1'b1, 12'h008, v8);
			{pcie, fep, msm} <= {i[3], 2'($urandom)};
			rd(12'h000, {1'b0, v0 & 32'hC0F000C3});
			rd(12'h004, {1'b0, v4 & 32'h3C0400FF});
			rd(12'h008, {1'b0, v8 & 32'h00000FFF});
			@(negedge core_clk);
			eE = i[1:0] == 2'h1 ? dat[1] : i[1:0] == 2'h2 ? dat[2] : dat[0];
			eF = i[0] ? dat[odd[i[2:1]]] : pcie ? dat[5] : dat[3];
			eT = dat[6 + v4[6:5]];
			sd = v4[2] ? v4[1] : sigRaw;
			@(negedge core_clk);
			chk(32'(encoderInput), 32'(eE));
			chk(32'(fifoInput), 32'(eF));
			chk(32'(checkerData), 32'(eT));
			chk(32'(signalDetect), 32'(sd));
			chk(32'(loopClk), 32'({v0[31:30], v0[23], v0[1:0] & {2{fep}}, v4[0] & fep, v4[7]}));
			chk(32'(drvOverride), 32'({v4[29:26], v8[11:8], v8[4:0], v4[18], v8[7:5]}));
		end
		$display("mux and override test done");
		for (int i = 0; i < 8; i++) begin
			v0 = ($urandom & 32'hFFCFFFFF) | (32'(i[1:0]) << 20);
			apb(1'b1, 12'h02C, v0);
			msm <= 1'($urandom);
			rd(12'h02C, {1'b0, v0});
			@(negedge core_clk);
			chk(32'(eqOverride), 32'({v0[2:1], v0[9:3], v0[18:12], v0[21:20], v0[23:22], v0[31:24]}));
			chk(32'(equalizerBiasPowerdown), 32'(v0[19] & msm));
		end
		$display("equalizer test done");
		for (int i = 0; i < 4; i++) begin
			v0 = ($urandom & 32'hFFC6FFFF) | (32'(i) << 19) | (32'(i[1]) << 16);
			v4 = ($urandom & 32'h3) | (32'(i[0]) << 6);
			apb(1'b1, 12'h030, v0);
			apb(1'b1, 12'h034, v4);
			rd(12'h030, {1'b0, v0 & 32'hFFFD3800});
			@(negedge core_clk);
			chk(32'(bistPattern), 32'({v4[1:0], v0[31:24], v0[16] & v4[0], v0[18], v0[21:19], wd[i], v0[23:22]}));
		end
		$display("pattern test done");
		// Forced signal detect and receive clock let the checker start
		apb(1'b1, 12'h030, 32'h00800000);
		apb(1'b1, 12'h004, 32'h0000000E);
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(checkerRun), 32'h1);
		chk(32'(checkerErrorCount != 16'h0), 32'h1);
		apb(1'b1, 12'h004, 32'h0000001E);
		repeat (2) @(negedge core_clk);
		chk(32'(checkerErrorCount), 32'h0);
		$display("checker test done");
		// Attenuator wait, equalizer wait and ready, then latch capture
		msm <= 1'b0;
		apb(1'b1, 12'h02C, 32'h00000403);
		apb(1'b1, 12'h004, 32'h00000004);
		// Longer than the bias recovery count left by earlier random writes
		repeat (1300) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(rxEn), 32'h0);
		chk(32'(attCalEnable), 32'h0);
		chk(32'(eqReady), 32'h1);
		apb(1'b1, 12'h004, 32'h00000006);
		repeat (8) @(negedge core_clk);
		chk(32'(attCalEnable), 32'h1);
		chk(32'(cdrSel), 32'h0);
		repeat (40) @(negedge core_clk);
		chk(32'(cdrSel), 32'h1);
		chk(32'(rxEn), 32'h1);
		apb(1'b1, 12'h02C, 32'h00000003);
		repeat (2) @(negedge core_clk);
		chk(32'(eqCapture), 32'h1);
		@(negedge core_clk);
		chk(32'(eqCapture), 32'h0);
		$display("cdr and latch test done");
		test_done();
	end
endmodule
